// file: hw/flash_status_write_enable.v
/*
 * status register and write-enable gating of a serial flash.
 * assumes an instruction decoder in front that presents one opcode
 * pulse per framed instruction, the write-status data byte with it,
 * and chip enable; array program/erase engines report back via done.
 */
`timescale 1ns/1ps
`include "flash_status_defs.vh"

// Functional notes
// R01 - register read repeats until chip enable high
// R02 - power-up loads volatile bits from stored
// R03 - eight-bit status layout, all zero default
// R04 - bit zero read-only busy flag
// R05 - busy during write cycles, clears on completion
// R06 - while busy accept only reads, resets, suspend
// R07 - write-class instructions need write enable latch
// R08 - opcode 06h sets write enable latch
// R09 - write disable clears the latch
// R10 - latch clears when write operation completes; volatile writes 63h, 83h and FBh leave it set
// R11 - status writes leave the latch set until their write cycle completes
// R12 - opcode 01h writes upper six bits
// R13 - bits two to five protect blocks
// R14 - bit six enables quad pins
// R15 - bit seven marks status write-protected
// R16 - host sends write enable before program/erase
// R17 - host sends write enable before register writes
// R18 - host sends write enable before protection ops
// R19 - opcode C0h needs no write enable
// R20 - protected status ignores write-status when pin low
// R21 - chip erase ignored unless protection zero
// R22 - host polls busy before next write
module flash_status_write_enable #(
  parameter BUSY_CYCLES = `BUSY_CYCLES
) (
  input wire clk_i,
  input wire sys_rst_i,
  input wire cmd_valid_i,
  input wire [7:0] cmd_opcode_i,
  input wire [7:0] cmd_data_i,
  input wire ce_n_i,
  input wire read_shift_i,
  input wire wp_n_i,
  input wire op_done_i,
  output reg [7:0] read_byte_o,
  output wire [7:0] flash_status_flags_o,
  output wire busy_flag_o,
  output wire write_enable_latch_o,
  output wire [3:0] block_protect_o,
  output wire quad_pin_enable_o,
  output wire status_write_disable_o,
  output wire op_start_o,
  output reg [7:0] op_opcode_o,
  output wire cmd_accept_o,
  output wire cmd_reject_o
);

  localparam ST_IDLE = 2'b00; // no internal cycle
  localparam ST_BUSY = 2'b01; // write cycle running
  localparam ST_SUSP = 2'b10; // program or erase suspended

  ////////////////////////////////////////////////////////////////
  // state
  reg [1:0] state_reg; // write-cycle state
  reg [1:0] state_next;
  reg latch_reg; // write enable latch
  reg latch_next;
  reg [5:0] vol_reg; // volatile copy of upper six bits
  reg [5:0] vol_next;
  reg [5:0] pend_reg; // data to store at cycle end
  reg [5:0] pend_next;
  reg nv_pend_reg; // stored-cell commit pending
  reg nv_pend_next;
  reg arr_op_reg; // current cycle is program/erase
  reg arr_op_next;
  reg [31:0] cnt_reg; // register write cycle timer
  reg [31:0] cnt_next;
  reg load_reg; // power-up load not yet done
  reg in_read_reg; // status read in this frame
  reg primed_reg = 1'b0; // set once the first reset has gone
  wire nv_por; // power-on reset of the stored cells
  wire [5:0] nv_q; // stored cells
  wire cycle_end; // write cycle finishing this clock
  wire reg_write_cycle; // cycle timed internally

  ////////////////////////////////////////////////////////////////
  // opcode classes
  reg is_latch_needed; // write-class instruction
  reg is_array_op; // program or erase of array
  reg is_busy_ok; // allowed while busy
  reg is_nv_write; // non-volatile register write
  always @*
  begin
    is_latch_needed = 1'b0;
    is_array_op = 1'b0;
    is_nv_write = 1'b0;
    case (cmd_opcode_i)
      `OP_PAGE_PROG, `OP_QUAD_PROG_A, `OP_QUAD_PROG_B, `OP_SECTOR_ERASE_A,
      `OP_SECTOR_ERASE_B, `OP_HALF_BLOCK_ERASE, `OP_BLOCK_ERASE, `OP_CHIP_ERASE_A,
      `OP_CHIP_ERASE_B, `OP_INFO_ERASE, `OP_INFO_PROG:
      begin
        is_latch_needed = 1'b1; // [R07]
        is_array_op = 1'b1;
      end
      `OP_STATUS_WRITE, `OP_FUNC_REG_WRITE, `OP_RD_PARAM_NV, `OP_EXT_PARAM_NV,
      `OP_AUTOBOOT_WRITE, `OP_PERS_PROT_PROG, `OP_PERS_PROT_ERASE, `OP_PROT_SETUP_PROG,
      `OP_LOCK_BIT_WRITE, `OP_FREEZE_SET, `OP_GANG_LOCK, `OP_GANG_UNLOCK,
      `OP_PASSWORD_PROG:
      begin
        is_latch_needed = 1'b1; // [R07]
        is_nv_write = 1'b1;
      end
      `OP_RD_PARAM_VOL, `OP_EXT_PARAM_VOL, `OP_DYN_PROT_WRITE:
      begin
        is_latch_needed = 1'b1; // volatile writes, no busy cycle
      end
      default:
      begin
        is_latch_needed = 1'b0; // C0h falls here: no latch needed [R19]
      end
    endcase
  end

  // reads and resets pass while busy; suspend passes only during program/erase
  always @*
  begin
    case (cmd_opcode_i)
      `OP_RDSR, `OP_RDERP, `OP_RST_EN, `OP_RST: is_busy_ok = 1'b1; // [R06]
      `OP_SUSPEND: is_busy_ok = arr_op_reg; // only program/erase [R06]
      default: is_busy_ok = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////
  // acceptance
  wire busy = (state_reg == ST_BUSY);
  wire is_chip_erase = (cmd_opcode_i == `OP_CHIP_ERASE_A)
    || (cmd_opcode_i == `OP_CHIP_ERASE_B);
  wire pin_lock = vol_reg[5] && !wp_n_i; // [R15] [R20]
  wire is_status_wr = (cmd_opcode_i == `OP_STATUS_WRITE);
  wire refuse = (busy && !is_busy_ok) // [R06]
    || (is_latch_needed && !latch_reg) // [R07]
    || (is_status_wr && pin_lock) // [R20]
    || (is_chip_erase && (vol_reg[3:0] != 4'h0)); // [R21]
  assign cmd_accept_o = cmd_valid_i && !refuse && !load_reg;
  assign cmd_reject_o = cmd_valid_i && (refuse || load_reg);
  wire start_cycle = cmd_accept_o && (is_array_op || is_nv_write);
  assign op_start_o = start_cycle && is_array_op;
  assign reg_write_cycle = !arr_op_reg;
  assign cycle_end = busy && (arr_op_reg ? op_done_i : (cnt_reg == 32'h0));

  ////////////////////////////////////////////////////////////////
  // next-state logic
  always @*
  begin
    state_next = state_reg;
    latch_next = latch_reg;
    vol_next = vol_reg;
    pend_next = pend_reg;
    nv_pend_next = 1'b0;
    arr_op_next = arr_op_reg;
    cnt_next = cnt_reg;
    if (load_reg)
    begin
      vol_next = nv_q; // [R02]
    end
    // write cycle progress
    if (busy && reg_write_cycle && cnt_reg != 32'h0)
    begin
      cnt_next = cnt_reg - 32'h1;
    end
    if (cycle_end)
    begin
      state_next = ST_IDLE; // done, success or not [R05]
      latch_next = 1'b0; // [R10]
      nv_pend_next = !arr_op_reg;
    end
    if (cmd_accept_o)
    begin
      case (cmd_opcode_i)
        `OP_WRITE_ENABLE: latch_next = 1'b1; // [R08]
        `OP_WRITE_DISABLE: latch_next = 1'b0; // [R09]
        `OP_VOL_STATUS_WRITE_ENABLE: latch_next = latch_reg; // latch untouched [R11]
        `OP_RST, `OP_RST_EN:
        begin
          if (cmd_opcode_i == `OP_RST)
          begin
            state_next = ST_IDLE; // reset aborts cycle
            latch_next = 1'b0;
          end
        end
        `OP_SUSPEND:
        begin
          if (busy)
          begin
            state_next = ST_SUSP;
          end
        end
        default:
        begin
          if (is_status_wr)
          begin
            vol_next = cmd_data_i[7:2]; // latch kept [R11] [R12]
            pend_next = cmd_data_i[7:2]; // [R12]
          end
        end
      endcase
      if (start_cycle)
      begin
        state_next = ST_BUSY; // [R05]
        arr_op_next = is_array_op;
        cnt_next = BUSY_CYCLES - 1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // registers
  always @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      state_reg <= ST_IDLE;
      latch_reg <= 1'b0; // [R03]
      vol_reg <= 6'h00;
      pend_reg <= 6'h00;
      nv_pend_reg <= 1'b0;
      arr_op_reg <= 1'b0;
      cnt_reg <= 32'h0;
      load_reg <= 1'b1; // reload stored bits after power-up [R02]
      op_opcode_o <= 8'h00;
    end
    else
    begin
      state_reg <= state_next;
      latch_reg <= latch_next;
      vol_reg <= vol_next;
      pend_reg <= pend_next;
      nv_pend_reg <= nv_pend_next;
      arr_op_reg <= arr_op_next;
      cnt_reg <= cnt_next;
      load_reg <= 1'b0;
      if (op_start_o)
      begin
        op_opcode_o <= cmd_opcode_i;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // power-up marker: only the very first reset is a power-on one;
  // without it the stored cells would start unknown, and a later
  // functional reset must not wipe them
  always @(posedge clk_i)
  begin
    if (!sys_rst_i)
    begin
      primed_reg <= 1'b1;
    end
  end
  assign nv_por = sys_rst_i && !primed_reg; // factory value once [R02]

  // stored cells keep their value across the functional reset
  status_nv_cells #(
    .WIDTH(6)
  ) u_nv (
    .clk_i(clk_i),
    .por_i(nv_por),
    .commit_i(nv_pend_reg),
    .data_i(pend_reg),
    .data_o(nv_q)
  );

  ////////////////////////////////////////////////////////////////
  // status read: the status byte repeats, resampled each byte, until chip enable rises
  always @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      in_read_reg <= 1'b0;
      read_byte_o <= `STAT_RESET;
    end
    else if (ce_n_i)
    begin
      in_read_reg <= 1'b0; // frame ended [R01]
    end
    else if (cmd_valid_i && cmd_opcode_i == `OP_RDSR)
    begin
      in_read_reg <= 1'b1;
      read_byte_o <= flash_status_flags_o;
    end
    else if (in_read_reg && read_shift_i)
    begin
      read_byte_o <= flash_status_flags_o; // refreshed each byte [R01]
    end
  end

  ////////////////////////////////////////////////////////////////
  // field outputs
  assign flash_status_flags_o = {vol_reg, latch_reg, busy}; // [R03] [R04]
  assign busy_flag_o = busy; // [R04]
  assign write_enable_latch_o = latch_reg;
  assign block_protect_o = vol_reg[3:0]; // [R13]
  assign quad_pin_enable_o = vol_reg[4]; // [R14]
  assign status_write_disable_o = vol_reg[5]; // [R15]

endmodule

// file: hw/flash_status_defs.vh
/*
 * constants for the flash status register and write-enable gating:
 * bit positions, reset value, opcodes and the busy-cycle time.
 * assumes inclusion by the status block and its stored-cell module.
 */
`ifndef FLASH_STATUS_DEFS_VH
`define FLASH_STATUS_DEFS_VH

// status register bit positions
`define STAT_BUSY_BIT 0
`define STAT_LATCH_BIT 1
`define STAT_BP_LSB 2
`define STAT_BP_MSB 5
`define STAT_QUAD_BIT 6
`define STAT_LOCK_BIT 7
`define STAT_RESET 8'h00
`define STAT_NV_FACTORY 6'h00

// opcodes
`define OP_WRITE_ENABLE 8'h06
`define OP_WRITE_DISABLE 8'h04
`define OP_STATUS_WRITE 8'h01
`define OP_VOL_STATUS_WRITE_ENABLE 8'h50
`define OP_RDSR 8'h05
`define OP_RDERP 8'h81
`define OP_RST_EN 8'h66
`define OP_RST 8'h99
`define OP_SUSPEND 8'h75
`define OP_PAGE_PROG 8'h02
`define OP_QUAD_PROG_A 8'h32
`define OP_QUAD_PROG_B 8'h38
`define OP_SECTOR_ERASE_A 8'hD7
`define OP_SECTOR_ERASE_B 8'h20
`define OP_HALF_BLOCK_ERASE 8'h52
`define OP_BLOCK_ERASE 8'hD8
`define OP_CHIP_ERASE_A 8'hC7
`define OP_CHIP_ERASE_B 8'h60
`define OP_FUNC_REG_WRITE 8'h42
`define OP_RD_PARAM_NV 8'h65
`define OP_RD_PARAM_VOL 8'h63
`define OP_RD_PARAM_VOL_FREE 8'hC0
`define OP_EXT_PARAM_NV 8'h85
`define OP_EXT_PARAM_VOL 8'h83
`define OP_INFO_ERASE 8'h64
`define OP_INFO_PROG 8'h62
`define OP_AUTOBOOT_WRITE 8'h15
`define OP_DYN_PROT_WRITE 8'hFB
`define OP_PERS_PROT_PROG 8'hFD
`define OP_PERS_PROT_ERASE 8'hE4
`define OP_PROT_SETUP_PROG 8'h2F
`define OP_LOCK_BIT_WRITE 8'hA6
`define OP_FREEZE_SET 8'h91
`define OP_GANG_LOCK 8'h7E
`define OP_GANG_UNLOCK 8'h98
`define OP_PASSWORD_PROG 8'hE8

// internal write cycle time, in microseconds, and cycles at 10 MHz
`define BUSY_TIME_US 100
`define CLK_MHZ 10
`define BUSY_CYCLES (`BUSY_TIME_US * `CLK_MHZ)

`endif

// file: hw/status_nv_cells.v
/*
 * non-volatile copy of the six writable status bits.
 * assumes a commit pulse once a write cycle ends; reset leaves the
 * cells alone except at first power-up where they hold the factory value.
 */
`timescale 1ns/1ps
`include "flash_status_defs.vh"

module status_nv_cells #(
  parameter WIDTH = 6
) (
  input wire clk_i,
  input wire por_i,
  input wire commit_i,
  input wire [WIDTH-1:0] data_i,
  output reg [WIDTH-1:0] data_o
);

  ////////////////////////////////////////////////////////////////
  // stored cells; only power-on forces the factory value
  always @(posedge clk_i or posedge por_i)
  begin
    if (por_i)
    begin
      data_o <= `STAT_NV_FACTORY;
    end
    else if (commit_i)
    begin
      data_o <= data_i;
    end
  end

endmodule

// file: sim/fsw_monitor.sv
/* assertions on the status block ports.
   assumes a bind onto the status block top. */
`timescale 1ns/1ps
module fsw_monitor (
  input wire clk_i,
  input wire sys_rst_i,
  input wire cmd_valid_i,
  input wire [7:0] cmd_opcode_i,
  input wire [7:0] cmd_data_i,
  input wire wp_n_i,
  input wire busy_flag_o,
  input wire write_enable_latch_o,
  input wire [3:0] block_protect_o,
  input wire status_write_disable_o,
  input wire cmd_accept_o,
  input wire cmd_reject_o,
  input wire op_start_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);
  // request, taken request, opcode
  wire rq = cmd_valid_i;
  wire tk = rq && cmd_accept_o;
  wire [7:0] op = cmd_opcode_i;
  // protect field as sent, kept for $past
  wire [3:0] bp_in = cmd_data_i[5:2];
  a_latch_set: assert property (tk && op == 8'h06 |=> write_enable_latch_o)
    else $error("latch not set");
  a_latch_clr: assert property (tk && op == 8'h04 |=> !write_enable_latch_o)
    else $error("latch not cleared");
  a_busy_drop: assert property (busy_flag_o && rq &&
    !(op inside {8'h05, 8'h81, 8'h66, 8'h99, 8'h75}) |-> !cmd_accept_o) else $error("busy took");
  a_latch_gate: assert property (rq && !write_enable_latch_o &&
    (op inside {8'h01, 8'h02, 8'h52, 8'hC7, 8'hE8}) |-> !cmd_accept_o) else $error("no latch");
  a_latch_kept: assert property (tk && op == 8'h01 |=> $stable(write_enable_latch_o))
    else $error("latch moved");
  a_busy_start: assert property (tk && op == 8'h01 |=> busy_flag_o)
    else $error("no busy");
  a_busy_end: assert property ($fell(busy_flag_o) && !$past(tk && op == 8'h75)
    |-> !write_enable_latch_o) else $error("latch kept");
  a_reject_pair: assert property (rq |-> cmd_reject_o != cmd_accept_o)
    else $error("accept and reject agree");
  a_start_array: assert property (tk && op == 8'h02 |-> op_start_o)
    else $error("no array start");
  a_pin_lock: assert property (rq && op == 8'h01 && status_write_disable_o &&
    !wp_n_i |-> !cmd_accept_o) else $error("locked write taken");
  a_erase_guard: assert property (rq && (op inside {8'hC7, 8'h60}) &&
    block_protect_o != 4'h0 |-> !cmd_accept_o) else $error("erase taken");
  a_bits_load: assert property (tk && op == 8'h01 |=> block_protect_o == $past(bp_in))
    else $error("protect bits");
  c_status_write_cmd: cover property (tk && op == 8'h01);
  c_refuse: cover property (busy_flag_o && rq && !cmd_accept_o);
  c_done: cover property ($fell(busy_flag_o));
endmodule
bind flash_status_write_enable fsw_monitor mon (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
  .cmd_valid_i(cmd_valid_i), .cmd_opcode_i(cmd_opcode_i), .cmd_data_i(cmd_data_i),
  .wp_n_i(wp_n_i), .busy_flag_o(busy_flag_o), .write_enable_latch_o(write_enable_latch_o),
  .block_protect_o(block_protect_o), .status_write_disable_o(status_write_disable_o),
  .cmd_accept_o(cmd_accept_o), .cmd_reject_o(cmd_reject_o), .op_start_o(op_start_o));

// file: sim/host_model.sv
/* host side model: frames instructions and reads status.
   assumes a decoder in the block that takes one opcode per frame. */
`timescale 1ns/1ps
module host_model (
  input wire clk_i,
  input wire busy_i,
  input wire accept_i,
  input wire [7:0] read_byte_i,
  output reg valid_o = 1'b0,
  output reg [7:0] opcode_o = 8'hA5,
  output reg [7:0] data_o = 8'h5A,
  output reg ce_n_o = 1'b1,
  output reg shift_o = 1'b0
);
  // one framed instruction; released lines show the inverse, not stale data
  task send(input [7:0] op, input [7:0] d, output a);
  begin
    @(posedge clk_i);
    #1 valid_o = 1'b1;
    ce_n_o = 1'b0;
    opcode_o = op;
    data_o = d;
    @(negedge clk_i);
    a = accept_i;
    @(posedge clk_i);
    #1 valid_o = 1'b0;
    ce_n_o = 1'b1;
    opcode_o = ~op;
    data_o = ~d;
  end
  endtask
  // one byte of a continuous status read; the first byte opens the
  // frame with the read opcode, chip enable stays low until the last
  task rd(input first, input last, output [7:0] b);
  begin
    @(posedge clk_i);
    #1 ce_n_o = 1'b0;
    valid_o = first;
    opcode_o = 8'h05;
    shift_o = !first;
    @(posedge clk_i);
    #1 valid_o = 1'b0;
    shift_o = 1'b0;
    opcode_o = 8'hFA;
    b = read_byte_i;
    ce_n_o = last;
  end
  endtask
  // wait for ready before any further write, bounded
  task poll;
    integer k;
  begin
    k = 0;
    while (busy_i !== 1'b0 && k < 50)
    begin
      @(posedge clk_i);
      #1 k = k + 1;
    end
  end
  endtask
endmodule

// file: sim/flash_status_write_enable_tb.sv
/* self-checking bench for the status block.
   assumes the host model and a busy cycle shortened to 4 clocks. */
`timescale 1ns/1ps
module flash_status_write_enable_tb;
  reg clk_i = 1'b0;
  reg sys_rst_i = 1'b1;
  reg wp_n_i = 1'b1;
  reg op_done_i = 1'b0;
  wire cmd_valid_i, ce_n_i, read_shift_i, busy_flag_o, write_enable_latch_o, cmd_reject_o;
  wire quad_pin_enable_o, status_write_disable_o, op_start_o, cmd_accept_o;
  wire [7:0] cmd_opcode_i, cmd_data_i, read_byte_o, flash_status_flags_o, op_opcode_o;
  wire [3:0] block_protect_o;
  // opcodes that need the latch first
  reg [215:0] wcl = {8'h02, 8'h32, 8'h38, 8'hD7, 8'h20, 8'h52, 8'hD8, 8'hC7, 8'h60,
    8'h01, 8'h42, 8'h65, 8'h63, 8'h85, 8'h83, 8'h64, 8'h62, 8'h15, 8'hFB, 8'hFD,
    8'hE4, 8'h2F, 8'hA6, 8'h91, 8'h7E, 8'h98, 8'hE8};
  integer n_fail = 0;
  integer n_tests = 0;
  integer i;
  reg acc;
  reg [7:0] rb;
  always #50 clk_i = ~clk_i;
  flash_status_write_enable #(.BUSY_CYCLES(4)) dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .cmd_valid_i(cmd_valid_i), .cmd_opcode_i(cmd_opcode_i), .cmd_data_i(cmd_data_i),
    .ce_n_i(ce_n_i), .read_shift_i(read_shift_i), .wp_n_i(wp_n_i), .op_done_i(op_done_i),
    .read_byte_o(read_byte_o), .flash_status_flags_o(flash_status_flags_o),
    .busy_flag_o(busy_flag_o), .write_enable_latch_o(write_enable_latch_o),
    .block_protect_o(block_protect_o), .quad_pin_enable_o(quad_pin_enable_o),
    .status_write_disable_o(status_write_disable_o), .op_start_o(op_start_o),
    .op_opcode_o(op_opcode_o), .cmd_accept_o(cmd_accept_o), .cmd_reject_o(cmd_reject_o));
  host_model host (.clk_i(clk_i), .busy_i(busy_flag_o), .accept_i(cmd_accept_o),
    .read_byte_i(read_byte_o), .valid_o(cmd_valid_i), .opcode_o(cmd_opcode_i),
    .data_o(cmd_data_i), .ce_n_o(ce_n_i), .shift_o(read_shift_i));
  ////////////////////////////////////////
  task chk(input [7:0] g, input [7:0] e);
  begin
    n_tests = n_tests + 1;
    if (g !== e)
    begin
      n_fail = n_fail + 1;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  end
  endtask
  // send and compare the accept answer
  task cmd(input [7:0] op, input [7:0] d, input e);
  begin
    host.send(op, d, acc);
    chk({7'h00, acc}, {7'h00, e});
  end
  endtask
  // two cycles of reset, then the load edge
  task rst;
  begin
    sys_rst_i = 1'b1;
    repeat (2) @(posedge clk_i);
    #1 sys_rst_i = 1'b0;
    @(posedge clk_i);
    #1;
  end
  endtask
  task results;
  begin
    $display("tests %0d fails %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  end
  endtask
  ////////////////////////////////////////
  initial
  begin
    rst;
    chk(flash_status_flags_o, 8'h00);
    for (i = 0; i < 27; i = i + 1)
      cmd(wcl[i*8 +: 8], 8'h00, 1'b0);
    chk(flash_status_flags_o, 8'h00);
    cmd(8'h06, 8'h00, 1'b1);
    chk(flash_status_flags_o, 8'h02);
    cmd(8'h04, 8'h00, 1'b1);
    chk(flash_status_flags_o, 8'h00);
    cmd(8'h06, 8'h00, 1'b1);
    cmd(8'h01, 8'hFC, 1'b1);
    chk(flash_status_flags_o, 8'hFF);
    cmd(8'h04, 8'h00, 1'b0);
    cmd(8'h05, 8'h00, 1'b1);
    host.poll;
    chk(flash_status_flags_o, 8'hFC);
    chk({2'b00, status_write_disable_o, quad_pin_enable_o, block_protect_o}, 8'h3F);
    for (i = 0; i < 3; i = i + 1)
    begin
      host.rd(i == 0, i == 2, rb);
      chk(rb, 8'hFC);
    end
    rst;
    chk(flash_status_flags_o, 8'hFC);
    cmd(8'h06, 8'h00, 1'b1);
    cmd(8'hC7, 8'h00, 1'b0);
    wp_n_i = 1'b0;
    cmd(8'h01, 8'h00, 1'b0);
    wp_n_i = 1'b1;
    cmd(8'h01, 8'h00, 1'b1);
    host.poll;
    chk(flash_status_flags_o, 8'h00);
    cmd(8'hC0, 8'h00, 1'b1);
    cmd(8'h06, 8'h00, 1'b1);
    cmd(8'h02, 8'h00, 1'b1);
    chk(op_opcode_o, 8'h02);
    chk(flash_status_flags_o, 8'h03);
    cmd(8'h81, 8'h00, 1'b1);
    cmd(8'h06, 8'h00, 1'b0);
    op_done_i = 1'b1;
    @(posedge clk_i);
    #1 op_done_i = 1'b0;
    host.poll;
    chk(flash_status_flags_o, 8'h00);
    results;
  end
  // watchdog, well past the expected run
  initial
  begin
    #300000;
    n_fail = n_fail + 1;
    results;
  end
endmodule
